// File: rtl/geom_pkg.sv
package geom_pkg;

    // ---------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_OUTPUT_FRAME_SIZE = 8'h00;
    localparam logic [7:0] ADDR_INPUT_WINDOW_START = 8'h04;
    localparam logic [7:0] ADDR_INPUT_FRAME_SIZE = 8'h08;
    localparam logic [7:0] ADDR_RESIZE_CONTROL = 8'h0C;
    localparam logic [7:0] ADDR_GEOMETRY_STATUS = 8'h10;

    // ---------------------------------------------------------------
    // field layouts
    // ---------------------------------------------------------------
    localparam int OUT_W_BITS = 11;
    localparam int IN_W_BITS = 13;
    localparam int HI_LSB = 16;
    localparam int SCALE_BITS = 10;
    localparam int CTRL_FORMAT_BIT = 27;
    localparam int CTRL_SOURCE_BIT = 28;
    localparam int CTRL_TAPS_BIT = 29;
    localparam int CTRL_SCALE_LSB = 10;

    // ---------------------------------------------------------------
    // reset values and limits
    // ---------------------------------------------------------------
    localparam logic [10:0] OUT_RESET = 11'h000;
    localparam logic [12:0] IN_RESET = 13'h0000;
    localparam logic [9:0] SCALE_RESET = 10'h0FF;
    localparam logic [9:0] SCALE_UNITY = 10'h100;
    localparam logic [9:0] SCALE_HALF = 10'h200;
    localparam logic [10:0] OUT_WIDTH_MAX = 11'h500;
    localparam logic [10:0] OUT_WIDTH_MAX_7TAP = 11'h280;
    localparam logic [12:0] HSTART_MAX_YUV = 13'h000F;
    localparam logic [12:0] HSTART_MAX_SEP = 13'h001F;
    localparam int ST_WIDTH_BIT = 0;
    localparam int ST_WIDTH7_BIT = 1;
    localparam int ST_EVEN_BIT = 2;
    localparam int ST_VSTART_BIT = 3;
    localparam int ST_HSTART_BIT = 4;
    localparam int ST_UPSIZE_BIT = 5;

    // ---------------------------------------------------------------
    // carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [10:0] out_height;
        logic [10:0] out_width;
        logic [12:0] vertical_start_line;
        logic [12:0] horizontal_start_pixel;
        logic [12:0] in_height;
        logic [12:0] in_width;
        logic input_format_select;
        logic source_sdram;
        logic seven_tap;
        logic [9:0] vertical_scale_value;
        logic [9:0] horizontal_scale_value;
    } geometry_t;

    typedef struct packed {
        logic upsize_vertical;
        logic bad_hstart;
        logic bad_vstart;
        logic odd_width;
        logic bad_width_7tap;
        logic bad_width;
    } geometry_check_t;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ACK
    } bus_state_t;

endpackage

// File: rtl/geometry_checker.sv
`timescale 1ns/1ns
// flags geometry values that break software programming limits
module geometry_checker
    import geom_pkg::*;
(
    // configuration in
    input wire geometry_t geom_i,
    // check flags out
    output geometry_check_t check_o
);

    // -------------------------------------------------------------
    // combinational checks
    // -------------------------------------------------------------
    logic [12:0] hstart_limit;
    logic down_more_than_two;

    // limit depends on input format
    assign hstart_limit = geom_i.input_format_select ? HSTART_MAX_SEP : HSTART_MAX_YUV;
    assign down_more_than_two = geom_i.horizontal_scale_value > SCALE_HALF;
    // ratio is 256 / value, so below 256 means upsizing
    assign check_o.upsize_vertical = geom_i.vertical_scale_value < SCALE_UNITY;
    assign check_o.bad_width = geom_i.out_width > OUT_WIDTH_MAX;
    assign check_o.bad_width_7tap = geom_i.seven_tap && down_more_than_two
        && (geom_i.out_width > OUT_WIDTH_MAX_7TAP);
    assign check_o.odd_width = check_o.upsize_vertical && geom_i.out_width[0];
    assign check_o.bad_vstart = geom_i.source_sdram && (geom_i.vertical_start_line != IN_RESET);
    assign check_o.bad_hstart = geom_i.source_sdram && (geom_i.horizontal_start_pixel > hstart_limit);

endmodule

// File: rtl/resizer_frame_geometry_regs.sv
`timescale 1ns/1ns
// Function
// - output height is an 11-bit read/write field at bits 26..16 of the output size register.
// - vertical start line is a 13-bit field at bits 28..16 of the start register, used for engine input.
// - with memory input, the 13-bit horizontal start at bits 12..0 counts pixels.
// - input height is a 13-bit read/write field at bits 28..16 of the input size register.
// - input width is a 13-bit read/write field at bits 12..0 of the input size register.
// - the format bit picks interleaved 16-bit data when clear and separate 8-bit data when set.
// - vertical ratio is 256 over the scale value, so a value below 256 means upsizing.
module resizer_frame_geometry_regs
    import geom_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // geometry to the scaler datapath
    output geometry_t geom_o,
    output logic [9:0] pixel_start_o,
    output logic start_in_bytes_o
);

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return a == ADDR_OUTPUT_FRAME_SIZE || a == ADDR_INPUT_WINDOW_START || a == ADDR_INPUT_FRAME_SIZE
            || a == ADDR_RESIZE_CONTROL || a == ADDR_GEOMETRY_STATUS;
    endfunction

    // -------------------------------------------------------------
    // bus handshake
    // -------------------------------------------------------------
    bus_state_t state;
    logic req;
    logic wr_take;
    logic [31:0] cur_word;
    logic [31:0] wr_word;
    geometry_check_t check;

    assign req = cyc_i && stb_i;
    // write is taken in the cycle before ack goes high
    assign wr_take = (state == BUS_IDLE) && req && we_i && is_mapped(adr_i);

    // one ack or err per request, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= BUS_IDLE;
        end else begin
            case (state)
                BUS_IDLE: begin
                    if (req) begin
                        state <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    state <= BUS_IDLE;
                end
                default: begin
                    state <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
        end else begin
            ack_o <= (state == BUS_IDLE) && req && is_mapped(adr_i);
            err_o <= (state == BUS_IDLE) && req && !is_mapped(adr_i);
        end
    end

    // -------------------------------------------------------------
    // readback word of the addressed register
    // -------------------------------------------------------------
    always_comb begin
        cur_word = 32'h0000_0000;
        case (adr_i)
            ADDR_OUTPUT_FRAME_SIZE: begin
                cur_word[HI_LSB +: OUT_W_BITS] = geom_o.out_height;
                cur_word[0 +: OUT_W_BITS] = geom_o.out_width;
            end
            ADDR_INPUT_WINDOW_START: begin
                cur_word[HI_LSB +: IN_W_BITS] = geom_o.vertical_start_line;
                cur_word[0 +: IN_W_BITS] = geom_o.horizontal_start_pixel;
            end
            ADDR_INPUT_FRAME_SIZE: begin
                cur_word[HI_LSB +: IN_W_BITS] = geom_o.in_height;
                cur_word[0 +: IN_W_BITS] = geom_o.in_width;
            end
            ADDR_RESIZE_CONTROL: begin
                cur_word[CTRL_TAPS_BIT] = geom_o.seven_tap;
                cur_word[CTRL_SOURCE_BIT] = geom_o.source_sdram;
                cur_word[CTRL_FORMAT_BIT] = geom_o.input_format_select;
                cur_word[CTRL_SCALE_LSB +: SCALE_BITS] = geom_o.vertical_scale_value;
                cur_word[0 +: SCALE_BITS] = geom_o.horizontal_scale_value;
            end
            ADDR_GEOMETRY_STATUS: begin
                cur_word[5:0] = check;
            end
            default: begin
                cur_word = 32'h0000_0000;
            end
        endcase
    end

    assign wr_word = merge(cur_word, dat_i, sel_i);

    // read data registered alongside ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if ((state == BUS_IDLE) && req && !we_i) begin
            dat_o <= cur_word;
        end
    end

    // -------------------------------------------------------------
    // output size register
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            geom_o.out_height <= OUT_RESET;
            geom_o.out_width <= OUT_RESET;
        end else if (wr_take && adr_i == ADDR_OUTPUT_FRAME_SIZE) begin
            geom_o.out_height <= wr_word[HI_LSB +: OUT_W_BITS];
            geom_o.out_width <= wr_word[0 +: OUT_W_BITS];
        end
    end

    // -------------------------------------------------------------
    // input window start register
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            geom_o.vertical_start_line <= IN_RESET;
            geom_o.horizontal_start_pixel <= IN_RESET;
        end else if (wr_take && adr_i == ADDR_INPUT_WINDOW_START) begin
            geom_o.vertical_start_line <= wr_word[HI_LSB +: IN_W_BITS];
            geom_o.horizontal_start_pixel <= wr_word[0 +: IN_W_BITS];
        end
    end

    // -------------------------------------------------------------
    // input size register
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            geom_o.in_height <= IN_RESET;
            geom_o.in_width <= IN_RESET;
        end else if (wr_take && adr_i == ADDR_INPUT_FRAME_SIZE) begin
            geom_o.in_height <= wr_word[HI_LSB +: IN_W_BITS];
            geom_o.in_width <= wr_word[0 +: IN_W_BITS];
        end
    end

    // -------------------------------------------------------------
    // resize control register
    // -------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            geom_o.input_format_select <= 1'b0;
            geom_o.source_sdram <= 1'b0;
            geom_o.seven_tap <= 1'b0;
            geom_o.vertical_scale_value <= SCALE_RESET;
            geom_o.horizontal_scale_value <= SCALE_RESET;
        end else if (wr_take && adr_i == ADDR_RESIZE_CONTROL) begin
            geom_o.input_format_select <= wr_word[CTRL_FORMAT_BIT];
            geom_o.source_sdram <= wr_word[CTRL_SOURCE_BIT];
            geom_o.seven_tap <= wr_word[CTRL_TAPS_BIT];
            geom_o.vertical_scale_value <= wr_word[CTRL_SCALE_LSB +: SCALE_BITS];
            geom_o.horizontal_scale_value <= wr_word[0 +: SCALE_BITS];
        end
    end

    // -------------------------------------------------------------
    // limit checks
    // -------------------------------------------------------------
    geometry_checker checker_u (
        .geom_i(geom_o),
        .check_o(check)
    );

    // -------------------------------------------------------------
    // start pixel as the datapath uses it
    // -------------------------------------------------------------
    // memory input: pixel count; engine input: byte count, halved
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pixel_start_o <= 10'h000;
            start_in_bytes_o <= 1'b0;
        end else begin
            start_in_bytes_o <= !geom_o.source_sdram;
            if (geom_o.source_sdram) begin
                pixel_start_o <= geom_o.horizontal_start_pixel[9:0];
            end else begin
                pixel_start_o <= geom_o.horizontal_start_pixel[10:1];
            end
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o) else $error("ack held for two cycles");
    a_height_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_OUTPUT_FRAME_SIZE && sel_i[2] && sel_i[3])
        |=> geom_o.out_height == $past(dat_i[26:16])) else $error("output height not stored");
    a_vstart_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_INPUT_WINDOW_START && sel_i == 4'hF)
        |=> geom_o.vertical_start_line == $past(dat_i[28:16])) else $error("vertical start not stored");
    a_hstart_pixels: assert property (@(posedge clk_i) disable iff (rst_i)
        geom_o.source_sdram && $stable(geom_o) |=> pixel_start_o == $past(geom_o.horizontal_start_pixel[9:0]))
        else $error("pixel start wrong for memory input");
    a_in_height_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_INPUT_FRAME_SIZE && sel_i == 4'hF)
        |=> geom_o.in_height == $past(dat_i[28:16])) else $error("input height not stored");
    a_in_width_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_INPUT_FRAME_SIZE && sel_i == 4'hF)
        |=> geom_o.in_width == $past(dat_i[12:0])) else $error("input width not stored");
    a_format_limit: assert property (@(posedge clk_i) disable iff (rst_i)
        geom_o.source_sdram && !geom_o.input_format_select && geom_o.horizontal_start_pixel == 13'h0010
        |-> check.bad_hstart) else $error("format limit wrong");
    a_upsize_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(adr_i) == ADDR_GEOMETRY_STATUS && !$past(we_i)
        |-> dat_o[ST_UPSIZE_BIT] == ($past(geom_o.vertical_scale_value) < SCALE_UNITY))
        else $error("upsize flag wrong");
    a_reserved_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(adr_i) == ADDR_INPUT_FRAME_SIZE && !$past(we_i)
        |-> dat_o[31:29] == 3'h0 && dat_o[15:13] == 3'h0) else $error("reserved bits not zero");
    c_write_out: cover property (@(posedge clk_i) wr_take && adr_i == ADDR_OUTPUT_FRAME_SIZE);
    c_read_status: cover property (@(posedge clk_i) ack_o && $past(adr_i) == ADDR_GEOMETRY_STATUS);
    c_error: cover property (@(posedge clk_i) err_o);
    c_hstart_over: cover property (@(posedge clk_i) !rst_i && check.bad_hstart);
    c_odd_upsize: cover property (@(posedge clk_i) !rst_i && check.odd_width);

    // -------------------------------------------------------------
    // handshake checks
    // -------------------------------------------------------------
    // a refused request answers with one error pulse, never with both answers
    a_err_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        err_o |=> !err_o) else $error("err held for two cycles");
    a_ack_err_apart: assert property (@(posedge clk_i) disable iff (rst_i)
        !(ack_o && err_o)) else $error("ack and err together");
    // a mapped request taken while idle is answered on the next edge
    a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
        (state == BUS_IDLE) && req && is_mapped(adr_i) |=> ack_o) else $error("ack missing");
    // status writes are acknowledged but change no field
    a_status_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_GEOMETRY_STATUS) |=> $stable(geom_o)) else $error("status write changed geometry");

    // -------------------------------------------------------------
    // field storage checks
    // -------------------------------------------------------------
    a_width_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_OUTPUT_FRAME_SIZE && sel_i[0] && sel_i[1])
        |=> geom_o.out_width == $past(dat_i[0 +: OUT_W_BITS])) else $error("output width not stored");
    a_hstart_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_take && adr_i == ADDR_INPUT_WINDOW_START && sel_i[0] && sel_i[1])
        |=> geom_o.horizontal_start_pixel == $past(dat_i[0 +: IN_W_BITS])) else $error("horizontal start not stored");
    // engine input: the start field is in bytes, the datapath gets the pixel index
    a_engine_bytes: assert property (@(posedge clk_i) disable iff (rst_i)
        !rst_i && !geom_o.source_sdram
        |=> start_in_bytes_o && pixel_start_o == $past(geom_o.horizontal_start_pixel[10:1]))
        else $error("engine start not halved");
    // the first edge after reset sees every size and start field cleared
    a_reset_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> geom_o.out_height == OUT_RESET && geom_o.out_width == OUT_RESET
        && geom_o.vertical_start_line == IN_RESET && geom_o.horizontal_start_pixel == IN_RESET
        && geom_o.in_height == IN_RESET && geom_o.in_width == IN_RESET) else $error("geometry not cleared by reset");

    // -------------------------------------------------------------
    // readback checks
    // -------------------------------------------------------------
    a_reserved_out: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(adr_i) == ADDR_OUTPUT_FRAME_SIZE && !$past(we_i)
        |-> dat_o[31:HI_LSB + OUT_W_BITS] == '0 && dat_o[HI_LSB - 1:OUT_W_BITS] == '0)
        else $error("output size reserved bits not zero");
    a_reserved_start: assert property (@(posedge clk_i) disable iff (rst_i)
        ack_o && $past(adr_i) == ADDR_INPUT_WINDOW_START && !$past(we_i)
        |-> dat_o[31:HI_LSB + IN_W_BITS] == '0 && dat_o[HI_LSB - 1:IN_W_BITS] == '0)
        else $error("input start reserved bits not zero");

endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
module tb_top
    import geom_pkg::*;
;
    // ---------------------------------------------------------------
    // clock, reset and bus signals
    // ---------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic ack_o;
    logic err_o;
    geometry_t geom_o;
    logic [9:0] pixel_start_o;
    logic start_in_bytes_o;
    integer failures = 0;
    integer checks_done = 0;
    integer seed = 32'hca37;
    bit [31:0] mdl [4];
    localparam bit [31:0] WMASK [4] = '{32'h07FF_07FF, 32'h1FFF_1FFF, 32'h1FFF_1FFF, 32'h380F_FFFF};
    localparam bit [31:0] RST_VAL [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0003_FCFF};
    localparam bit [7:0] ADDRS [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'hFC};
    // boundary table: control, output size, input start
    localparam bit [31:0] DIR [18] = '{
        32'h3008_0200, 32'h0001_0281, 32'h0000_000F, 32'h3008_0201, 32'h0000_0281, 32'h0000_0010,
        32'h3808_0201, 32'h0000_0280, 32'h0001_001F, 32'h1803_FC00, 32'h0000_0501, 32'h0000_0020,
        32'h0004_0100, 32'h0000_0500, 32'h0000_0003, 32'h0003_FC00, 32'h0000_0501, 32'h0001_0011};

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    resizer_frame_geometry_regs i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .geom_o(geom_o),
        .pixel_start_o(pixel_start_o), .start_in_bytes_o(start_in_bytes_o));

    // ---------------------------------------------------------------
    // reference model
    // ---------------------------------------------------------------
    function automatic bit [31:0] status_exp();
        bit [31:0] s;
        bit [10:0] w;
        bit [9:0] vsc;
        s = 32'h0000_0000;
        w = mdl[0][10:0];
        vsc = mdl[3][19:10];
        s[ST_WIDTH_BIT] = w > OUT_WIDTH_MAX;
        s[ST_WIDTH7_BIT] = mdl[3][29] && mdl[3][9:0] > SCALE_HALF && w > OUT_WIDTH_MAX_7TAP;
        s[ST_EVEN_BIT] = vsc < SCALE_UNITY && w[0];
        s[ST_VSTART_BIT] = mdl[3][28] && mdl[1][28:16] != 13'h0000;
        s[ST_HSTART_BIT] = mdl[3][28] && mdl[1][12:0] > (mdl[3][27] ? HSTART_MAX_SEP : HSTART_MAX_YUV);
        s[ST_UPSIZE_BIT] = vsc < SCALE_UNITY;
        return s;
    endfunction

    function automatic bit mapped(input bit [7:0] a);
        return a <= ADDR_GEOMETRY_STATUS && a[1:0] == 2'b00;
    endfunction

    function automatic bit [31:0] reg_exp(input bit [7:0] a);
        if (a == ADDR_GEOMETRY_STATUS) begin
            return status_exp();
        end
        return mdl[a[3:2]];
    endfunction

    function automatic geometry_t geom_exp();
        geometry_t g;
        g.out_height = mdl[0][26:16];
        g.out_width = mdl[0][10:0];
        g.vertical_start_line = mdl[1][28:16];
        g.horizontal_start_pixel = mdl[1][12:0];
        g.in_height = mdl[2][28:16];
        g.in_width = mdl[2][12:0];
        g.input_format_select = mdl[3][27];
        g.source_sdram = mdl[3][28];
        g.seven_tap = mdl[3][29];
        g.vertical_scale_value = mdl[3][19:10];
        g.horizontal_scale_value = mdl[3][9:0];
        return g;
    endfunction

    // ---------------------------------------------------------------
    // checking and bus tasks
    // ---------------------------------------------------------------
    task automatic final_report();
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one classic cycle, waits for ack or err under a bound
    task automatic wb(input bit w, input bit [7:0] a, input bit [3:0] s, input bit [31:0] d);
        int n;
        logic [31:0] rd;
        logic ak;
        logic er;
        bit [31:0] bm;
        bit [31:0] ex;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= d;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        rd = dat_o;
        ak = ack_o;
        er = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        if (ak !== 1'b1 && er !== 1'b1) begin
            failures++;
            final_report();
        end
        check(128'(ak), 128'(mapped(a)));
        check(128'(er), 128'(!mapped(a)));
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (w && mapped(a) && a != ADDR_GEOMETRY_STATUS) begin
            mdl[a[3:2]] = (mdl[a[3:2]] & ~bm) | (d & bm & WMASK[a[3:2]]);
        end
        if (!w) begin
            // a read of an unmapped place loads a zero word into the read data register
            ex = mapped(a) ? reg_exp(a) : 32'h0000_0000;
            if (a == ADDR_GEOMETRY_STATUS) begin
                check(128'(rd), 128'(ex));
            end else begin
                check(128'(rd), 128'(ex));
            end
        end
    endtask

    // datapath outputs against the model, sampled clear of the edge
    task automatic check_outs();
        @(posedge clk_i);
        #1;
        check(128'(geom_o), 128'(geom_exp()));
        check(128'(pixel_start_o), 128'(mdl[3][28] ? mdl[1][9:0] : mdl[1][10:1]));
        check(128'(start_in_bytes_o), 128'(!mdl[3][28]));
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        mdl = RST_VAL;
    endtask

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        bit [31:0] r;
        do_reset();
        check_outs(); // reset values of every field
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, ADDRS[i], 4'hF, 32'h0000_0000);
        end
        // all ones: reserved bits stay clear, status ignores writes
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, ADDRS[i], 4'hF, 32'hFFFF_FFFF);
            wb(1'b0, ADDRS[i], 4'hF, 32'h0000_0000);
        end
        check_outs();
        // limit boundaries per source, format and direction
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, ADDR_RESIZE_CONTROL, 4'hF, DIR[3 * i]);
            wb(1'b1, ADDR_OUTPUT_FRAME_SIZE, 4'hF, DIR[3 * i + 1]);
            wb(1'b1, ADDR_INPUT_WINDOW_START, 4'hF, DIR[3 * i + 2]);
            wb(1'b0, ADDR_GEOMETRY_STATUS, 4'hF, 32'h0000_0000);
            check_outs();
        end
        // random traffic with byte enables and unmapped places
        for (int i = 0; i < 120; i++) begin
            r = $random(seed);
            wb(r[0], ADDRS[$unsigned($random(seed)) % 7], r[4:1], $random(seed));
            if (i % 8 == 0) begin
                check_outs();
            end
        end
        // second reset in mid-run
        do_reset();
        check_outs();
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, ADDRS[i], 4'hF, 32'h0000_0000);
        end
        final_report();
    end
endmodule
